/* inc/ats_pkg.sv */
// Shared constants, types and helpers of the acquisition trigger sequencer
package ats_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_BURST  = 8'h04;
  localparam logic [7:0] OFS_PERIOD = 8'h08;
  localparam logic [7:0] OFS_MINPER = 8'h0C;
  localparam logic [7:0] OFS_CMD    = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_FRAMES = 8'h18;
  localparam logic [7:0] OFS_MISSED = 8'h1C;

  // Widths
  localparam int NLINE    = 4;
  localparam int CTRL_W   = 12;
  localparam int CNT_W    = 16;
  localparam int STAT_LSB = 16;

  // Command bits
  localparam int CMD_AS_BIT = 0;
  localparam int CMD_FS_BIT = 1;

  // Reset values, increment steps and the saturation limit
  localparam logic [CTRL_W-1:0] CTRL_RST   = 12'h000;
  localparam logic [CNT_W-1:0]  BURST_RST  = 16'h0001;
  localparam logic [31:0]       PERIOD_RST = 32'h0000_03E8;
  localparam logic [31:0]       MINPER_RST = 32'h0000_0010;
  localparam logic [CNT_W-1:0]  CNT_ONE    = 16'h0001;
  localparam logic [31:0]       WORD_ONE   = 32'h0000_0001;
  localparam logic [31:0]       WORD_MAX   = 32'hFFFF_FFFF;

  // Control register layout, bit 0 is acq_en
  typedef struct packed {
    logic [1:0] fs_line;
    logic [1:0] as_line;
    logic       rate_en;
    logic       fs_fall;
    logic       fs_sw;
    logic       fs_mode;
    logic       as_fall;
    logic       as_sw;
    logic       as_mode;
    logic       acq_en;
  } ats_ctrl_s;

  // Trigger events of one cycle
  typedef struct packed {
    logic as_ev;
    logic fs_ev;
  } ats_evt_s;

  // Acquisition status
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_WAIT_AS = 3'b010,
    ST_WAIT_FS = 3'b100
  } ats_state_e;

  // Picks the selected line's rising or falling edge pulse
  function automatic logic ats_sel_edge(input logic [NLINE-1:0] rise,
                                        input logic [NLINE-1:0] fall,
                                        input logic [1:0]       sel,
                                        input logic             use_fall);
    ats_sel_edge = use_fall ? fall[sel] : rise[sel];
  endfunction : ats_sel_edge

  // Larger of two periods
  function automatic logic [31:0] ats_max(input logic [31:0] a,
                                          input logic [31:0] b);
    ats_max = (a > b) ? a : b;
  endfunction : ats_max

endpackage : ats_pkg

/* verilog/ats_line_edge.sv */
// Input line synchroniser and edge detector
`timescale 1ns/1ps
module ats_line_edge
  import ats_pkg::*;
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Raw input lines
  input  wire logic [NLINE-1:0] line_i,
  // Edge pulses, one cycle each
  output logic      [NLINE-1:0] rise,
  output logic      [NLINE-1:0] fall
);

  logic [NLINE-1:0] sync1_r;
  logic [NLINE-1:0] sync2_r;
  logic [NLINE-1:0] prev_r;
  logic [NLINE-1:0] sync1_nxt;
  logic [NLINE-1:0] sync2_nxt;
  logic [NLINE-1:0] prev_nxt;

  // Two-stage synchroniser, then a history stage for edges
  always_comb begin
    sync1_nxt = line_i;
    sync2_nxt = sync1_r;
    prev_nxt  = sync2_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r  <= prev_nxt;
    end
  end

  // Edges only from synchronised stages
  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;

endmodule : ats_line_edge

/* verilog/ats_seq.sv */
// Acquisition and frame start trigger sequencer with APB registers
`timescale 1ns/1ps

module ats_seq
  import ats_pkg::*;
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // External trigger lines
  input  wire logic [NLINE-1:0] line_i,
  // Sequencer outputs
  output logic                  frame_start_o,
  output logic                  wait_as_o,
  output logic                  wait_fs_o
);

  // Register state
  ats_ctrl_s        ctrl_r;
  ats_ctrl_s        ctrl_nxt;
  logic [CNT_W-1:0] burst_r;
  logic [CNT_W-1:0] burst_nxt;
  logic [31:0]      period_r;
  logic [31:0]      period_nxt;
  logic [31:0]      minper_r;
  logic [31:0]      minper_nxt;
  logic             sw_as_r;
  logic             sw_as_nxt;
  logic             sw_fs_r;
  logic             sw_fs_nxt;
  logic [31:0]      prdata_r;
  logic [31:0]      prdata_nxt;
  logic             pready_r;
  logic             pready_nxt;
  logic             pslverr_r;
  logic             pslverr_nxt;

  // Sequencer state
  ats_state_e       state_r;
  ats_state_e       state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [31:0]      timer_r;
  logic [31:0]      timer_nxt;
  logic [31:0]      frames_r;
  logic [31:0]      frames_nxt;
  logic [31:0]      missed_r;
  logic [31:0]      missed_nxt;
  logic             frame_r;
  logic             frame_nxt;
  logic             wait_as_r;
  logic             wait_as_nxt;
  logic             wait_fs_r;
  logic             wait_fs_nxt;

  // Combinational helpers
  logic [NLINE-1:0] rise;
  logic [NLINE-1:0] fall;
  logic             as_line_hit;
  logic             fs_line_hit;
  logic             fs_ext_ev;
  logic [31:0]      eff_per;
  logic             pace_due;
  logic [CNT_W-1:0] burst_eff;
  logic             last_frame;
  logic             frame_acc;
  logic             as_acc;
  ats_evt_s         evt;
  logic             setup;
  logic             acc_wr;
  logic             mapped;

  // Line synchronisers and edge detection
  ats_line_edge u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .line_i  (line_i),
    .rise    (rise),
    .fall    (fall)
  );

  // Trigger event selection and pacing
  always_comb begin
    as_line_hit = ats_sel_edge(rise, fall, ctrl_r.as_line, ctrl_r.as_fall);
    fs_line_hit = ats_sel_edge(rise, fall, ctrl_r.fs_line, ctrl_r.fs_fall);
    // Pacing never beats the minimum period
    eff_per  = ctrl_r.rate_en ? ats_max(period_r, minper_r) : minper_r;
    pace_due = (timer_r >= eff_per);
    // Internal start when mode off, else line edge or command
    evt.as_ev = ctrl_r.as_mode
              ? (ctrl_r.as_sw ? sw_as_r : as_line_hit) : 1'b1;
    fs_ext_ev = ctrl_r.fs_sw ? sw_fs_r : fs_line_hit;
    evt.fs_ev = ctrl_r.fs_mode ? fs_ext_ev : pace_due;
    burst_eff  = (burst_r == '0) ? CNT_ONE : burst_r;
    last_frame = ((cnt_r + CNT_ONE) >= burst_eff) || (cnt_r == '1);
    // Acceptance gated by the state
    as_acc    = (state_r == ST_WAIT_AS) && ctrl_r.acq_en && evt.as_ev;
    frame_acc = (state_r == ST_WAIT_FS) && ctrl_r.acq_en && evt.fs_ev;
  end

  // Sequencer next state
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    timer_nxt  = (timer_r == WORD_MAX) ? timer_r : timer_r + WORD_ONE;
    frames_nxt = frames_r;
    missed_nxt = missed_r;
    frame_nxt  = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (ctrl_r.acq_en) begin
          state_nxt = ST_WAIT_AS;
        end
      end
      ST_WAIT_AS: begin
        if (!ctrl_r.acq_en) begin
          state_nxt = ST_IDLE;
        end else if (as_acc) begin
          state_nxt = ST_WAIT_FS;
          cnt_nxt   = '0;
        end
      end
      ST_WAIT_FS: begin
        if (!ctrl_r.acq_en) begin
          state_nxt = ST_IDLE;
        end else if (frame_acc) begin
          cnt_nxt    = cnt_r + CNT_ONE;
          timer_nxt  = '0;
          frames_nxt = frames_r + WORD_ONE;
          frame_nxt  = 1'b1;
          if (last_frame) begin
            state_nxt = ST_WAIT_AS;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // External frame starts outside waiting-for-frame-start are dropped
    if (ctrl_r.fs_mode && fs_ext_ev && (state_r != ST_WAIT_FS)) begin
      missed_nxt = missed_r + WORD_ONE;
    end
    wait_as_nxt = (state_nxt == ST_WAIT_AS);
    wait_fs_nxt = (state_nxt == ST_WAIT_FS);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= ST_IDLE;
      cnt_r     <= '0;
      timer_r   <= '0;
      frames_r  <= '0;
      missed_r  <= '0;
      frame_r   <= 1'b0;
      wait_as_r <= 1'b0;
      wait_fs_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      timer_r   <= timer_nxt;
      frames_r  <= frames_nxt;
      missed_r  <= missed_nxt;
      frame_r   <= frame_nxt;
      wait_as_r <= wait_as_nxt;
      wait_fs_r <= wait_fs_nxt;
    end
  end

  // APB decode, register writes and registered read answer
  always_comb begin
    setup  = psel && !penable;
    acc_wr = psel && penable && pready_r && pwrite;
    mapped = (paddr == OFS_CTRL)   || (paddr == OFS_BURST)  ||
             (paddr == OFS_PERIOD) || (paddr == OFS_MINPER) ||
             (paddr == OFS_CMD)    || (paddr == OFS_STATUS) ||
             (paddr == OFS_FRAMES) || (paddr == OFS_MISSED);
    ctrl_nxt   = ctrl_r;
    burst_nxt  = burst_r;
    period_nxt = period_r;
    minper_nxt = minper_r;
    sw_as_nxt  = 1'b0;
    sw_fs_nxt  = 1'b0;
    if (acc_wr) begin
      case (paddr)
        OFS_CTRL:   ctrl_nxt   = ats_ctrl_s'(pwdata[CTRL_W-1:0]);
        OFS_BURST:  burst_nxt  = pwdata[CNT_W-1:0];
        OFS_PERIOD: period_nxt = pwdata;
        OFS_MINPER: minper_nxt = pwdata;
        OFS_CMD: begin
          sw_as_nxt = pwdata[CMD_AS_BIT];
          sw_fs_nxt = pwdata[CMD_FS_BIT];
        end
        default: begin
        end
      endcase
    end
    pready_nxt  = setup;
    pslverr_nxt = setup && !mapped;
    prdata_nxt  = '0;
    if (setup && !pwrite) begin
      case (paddr)
        OFS_CTRL:   prdata_nxt = {{(32-CTRL_W){1'b0}}, ctrl_r};
        OFS_BURST:  prdata_nxt = {{(32-CNT_W){1'b0}}, burst_r};
        OFS_PERIOD: prdata_nxt = period_r;
        OFS_MINPER: prdata_nxt = minper_r;
        OFS_STATUS: prdata_nxt = {cnt_r, {(STAT_LSB-3){1'b0}}, state_r};
        OFS_FRAMES: prdata_nxt = frames_r;
        OFS_MISSED: prdata_nxt = missed_r;
        default:    prdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= ats_ctrl_s'(CTRL_RST);
      burst_r   <= BURST_RST;
      period_r  <= PERIOD_RST;
      minper_r  <= MINPER_RST;
      sw_as_r   <= 1'b0;
      sw_fs_r   <= 1'b0;
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      burst_r   <= burst_nxt;
      period_r  <= period_nxt;
      minper_r  <= minper_nxt;
      sw_as_r   <= sw_as_nxt;
      sw_fs_r   <= sw_fs_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Outputs straight from flops
  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign frame_start_o = frame_r;
  assign wait_as_o     = wait_as_r;
  assign wait_fs_o     = wait_fs_r;

  // Checks on sequencing
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_line_acq_start:
    assert property (state_r == ST_WAIT_AS && ctrl_r.acq_en &&
      ctrl_r.as_mode && !ctrl_r.as_sw && as_line_hit
      |=> state_r == ST_WAIT_FS && wait_fs_o)
    else $error("line edge did not start the burst");

  a_burst_return:
    assert property (frame_acc && last_frame
      |=> state_r == ST_WAIT_AS && frame_start_o && wait_as_o)
    else $error("burst did not end after its frame count");

  a_no_frame_wait:
    assert property (state_r != ST_WAIT_FS |=> !frame_start_o)
    else $error("frame started outside waiting for frame start");

  a_pace_hold:
    assert property (state_r == ST_WAIT_FS && !ctrl_r.fs_mode &&
      timer_r < eff_per |=> !frame_start_o)
    else $error("internal frame start came before its period");

  a_max_rate:
    assert property (state_r == ST_WAIT_FS && ctrl_r.acq_en &&
      !ctrl_r.fs_mode && !ctrl_r.rate_en && timer_r == minper_r
      |=> frame_start_o)
    else $error("unpaced frame start missed the minimum period");

  a_sw_acq_start:
    assert property (state_r == ST_WAIT_AS && ctrl_r.acq_en &&
      ctrl_r.as_mode && ctrl_r.as_sw && sw_as_r
      |=> state_r == ST_WAIT_FS && cnt_r == '0)
    else $error("software command did not start the burst");

  a_ignore_fs:
    assert property (ctrl_r.fs_mode && fs_ext_ev && state_r != ST_WAIT_FS
      |=> missed_r == $past(missed_r) + WORD_ONE && !frame_start_o)
    else $error("stray frame start was not ignored");

  a_free_run:
    assert property (state_r == ST_WAIT_AS && ctrl_r.acq_en &&
      !ctrl_r.as_mode && $stable(ctrl_r) |=> state_r == ST_WAIT_FS)
    else $error("internal start did not restart the burst");

  a_count_step:
    assert property (frame_acc |=> cnt_r == $past(cnt_r) + CNT_ONE)
    else $error("burst counter did not count a frame");

endmodule : ats_seq

/* dv/ats_trig_src.sv */
// Model of the external sensing devices that drive the trigger lines
`timescale 1ns/1ps
module ats_trig_src
  import ats_pkg::*;
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Pulse request from the bench
  input  wire logic             req,
  input  wire logic [1:0]       sel,
  // Trigger lines, idle low
  output logic      [NLINE-1:0] line_i
);
  logic [2:0] hold_r;

  // One clean rising edge per request, then high for four cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= 3'h0;
      line_i <= '0;
    end else begin
      if (req) begin
        hold_r <= 3'h4;
      end else if (hold_r != 3'h0) begin
        hold_r <= hold_r - 3'h1;
      end
      line_i <= (req || hold_r > 3'h1) ? (4'h1 << sel) : 4'h0;
    end
  end
endmodule : ats_trig_src

/* dv/testbench.sv */
// Self-checking bench of the trigger sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import ats_pkg::*;
  typedef struct { logic [7:0] a; logic [31:0] d; logic e; } ats_row_s;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             req = 1'b0;
  logic [NLINE-1:0] line_i;
  logic             frame_start_o;
  logic             wait_as_o;
  logic             wait_fs_o;
  logic [31:0]      rd;
  logic             er;
  int               num_errors = 0;
  int               checks_done = 0;
  int               n;
  int               g;
  ats_row_s rows [9] = '{'{OFS_CTRL, 32'h0, 1'b0}, '{OFS_BURST, 32'h1, 1'b0},
    '{OFS_PERIOD, 32'h3E8, 1'b0}, '{OFS_MINPER, 32'h10, 1'b0},
    '{OFS_CMD, 32'h0, 1'b0}, '{OFS_STATUS, 32'h1, 1'b0},
    '{OFS_FRAMES, 32'h0, 1'b0}, '{OFS_MISSED, 32'h0, 1'b0},
    '{8'h20, 32'h0, 1'b1}};

  // Clock
  always #2 pclk = ~pclk;

  ats_seq uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_i(line_i),
    .frame_start_o(frame_start_o), .wait_as_o(wait_as_o),
    .wait_fs_o(wait_fs_o));
  ats_trig_src src (.pclk(pclk), .presetn(presetn), .req(req),
    .sel(2'h1), .line_i(line_i));

  // One APB transfer; request held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    `CHK(pready, 1'b1)
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Waits for the wait flags to show a value, bounded
  task automatic wait_st(input logic [1:0] want);
    int k;
    k = 0;
    while ({wait_fs_o, wait_as_o} !== want && k < 60) begin
      @(posedge pclk);
      k++;
    end
    `CHK({wait_fs_o, wait_as_o}, want)
  endtask : wait_st

  // Counts frame pulses over a number of cycles
  task automatic cnt(input int c);
    n = 0;
    repeat (c) begin
      @(posedge pclk);
      if (frame_start_o === 1'b1) n++;
    end
  endtask : cnt

  // Cycles between two consecutive frame pulses
  task automatic gap;
    g = 0;
    do begin
      @(posedge pclk);
      g++;
    end while (frame_start_o !== 1'b1 && g < 500);
    g = 0;
    do begin
      @(posedge pclk);
      g++;
    end while (frame_start_o !== 1'b1 && g < 500);
  endtask : gap

  // One trigger edge on line 1
  task automatic pulse;
    @(posedge pclk);
    req <= 1'b1;
    @(posedge pclk);
    req <= 1'b0;
  endtask : pulse

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    report_and_stop();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    `CHK({frame_start_o, wait_as_o, wait_fs_o}, 3'b000)
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      `CHK(rd, rows[i].d)
      `CHK(er, rows[i].e)
    end
    $display("Done: register table");
    // Line start, internal frames, burst of three
    apb(1'b1, OFS_BURST, 32'h3);
    apb(1'b1, OFS_CTRL, 32'h103);
    wait_st(2'b01);
    cnt(40);
    `CHK(n, 0)
    pulse();
    wait_st(2'b10);
    cnt(120);
    `CHK(n, 3)
    wait_st(2'b01);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd, 32'h0003_0002)
    cnt(100);
    `CHK(n, 0)
    pulse();
    wait_st(2'b10);
    gap();
    `CHK(g, 17)
    $display("Done: line start burst");
    // Software start, line frame starts
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h417);
    wait_st(2'b01);
    pulse();
    cnt(20);
    `CHK(n, 0)
    apb(1'b0, OFS_MISSED, 32'h0);
    `CHK(rd, 32'h1)
    apb(1'b1, OFS_CMD, 32'h1);
    wait_st(2'b10);
    cnt(30);
    `CHK(n, 0)
    repeat (3) begin
      pulse();
      cnt(20);
      `CHK(n, 1)
    end
    wait_st(2'b01);
    pulse();
    cnt(20);
    `CHK(n, 0)
    $display("Done: software start burst");
    // Both triggers internal
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_PERIOD, 32'd40);
    apb(1'b1, OFS_CTRL, 32'h81);
    gap();
    `CHK(g, 41)
    apb(1'b1, OFS_CTRL, 32'h1);
    cnt(200);
    `CHK(n >= 10, 1'b1)
    $display("Done: free run");
    // Falling-edge start on line 1, software frame starts
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h13B);
    wait_st(2'b01);
    pulse();
    repeat (4) @(posedge pclk);
    `CHK({wait_fs_o, wait_as_o}, 2'b01)
    wait_st(2'b10);
    repeat (3) begin
      apb(1'b1, OFS_CMD, 32'h2);
      cnt(4);
      `CHK(n, 1)
    end
    wait_st(2'b01);
    apb(1'b1, OFS_CMD, 32'h2);
    cnt(4);
    `CHK(n, 0)
    apb(1'b0, OFS_MISSED, 32'h0);
    `CHK(rd, 32'h3)
    $display("Done: falling start, software frames");
    // Refused write and reset in mid-run
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    `CHK(er, 1'b1)
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK({frame_start_o, wait_as_o, wait_fs_o}, 3'b000)
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    $display("Done: refusal and reset");
    report_and_stop();
  end
endmodule : testbench
